// *** common/prp_pkg.sv ***
// ****************************************
// pump remote parallel port constants
// ****************************************
package prp_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int PRP_CLK_HZ       = 25_000_000;
    localparam int PRP_CYC_PER_MS   = PRP_CLK_HZ / 1000;
    localparam int PRP_FILT_MS      = 20;
    localparam int PRP_START_MIN_MS = 300;
    localparam int PRP_PWRUP_MIN_MS = 10_000;
    localparam int PRP_CLR_MIN_MS   = 300;
    localparam int PRP_FILT_CYC     = PRP_FILT_MS * PRP_CYC_PER_MS;
    localparam int PRP_START_CYC    = PRP_START_MIN_MS * PRP_CYC_PER_MS;
    localparam int PRP_PWRUP_CYC    = PRP_PWRUP_MIN_MS * PRP_CYC_PER_MS;
    localparam int PRP_CLR_CYC      = PRP_CLR_MIN_MS * PRP_CYC_PER_MS;
    localparam int PRP_HOLD_W       = 28;

    // ****************************************
    // contact input indices
    // ****************************************
    localparam int PRP_NC        = 7;
    localparam int PRP_CI_START  = 0;
    localparam int PRP_CI_HOLD   = 1;
    localparam int PRP_CI_CLR    = 2;
    localparam int PRP_CI_BLOCK  = 3;
    localparam int PRP_CI_SEL    = 4;
    localparam int PRP_CI_PSTART = 5;
    localparam int PRP_CI_PSTOP  = 6;

    // ****************************************
    // thermal window
    // ****************************************
    localparam int PRP_TEMP_W     = 9;
    localparam int PRP_THERM_BAND = 10;

    // ****************************************
    // pump state
    // ****************************************
    typedef enum logic [1:0] {
        PRP_ST_IDLE  = 2'b00,
        PRP_ST_ACCEL = 2'b01,
        PRP_ST_RATED = 2'b10,
        PRP_ST_BRAKE = 2'b11
    } prp_state_type;

endpackage

// *** verilog/prp_remote_io.sv ***
`timescale 1ns/1ps
module prp_remote_io
    import prp_pkg::*;
#(
    parameter int FILT_CYC  = PRP_FILT_CYC,
    parameter int START_CYC = PRP_START_CYC,
    parameter int PWRUP_CYC = PRP_PWRUP_CYC,
    parameter int CLR_CYC   = PRP_CLR_CYC
)(
    input  wire logic                  ref_clk_in,
    input  wire logic                  rstn_in,
    input  wire logic                  start_contact_in,
    input  wire logic                  stop_hold_contact_in,
    input  wire logic                  fault_clear_contact_in,
    input  wire logic                  rot_block_contact_in,
    input  wire logic                  remote_select_in,
    input  wire logic                  panel_start_in,
    input  wire logic                  panel_stop_in,
    input  wire logic                  single_contact_mode_in,
    input  wire logic                  rot_block_enable_in,
    input  wire logic                  power_good_in,
    input  wire logic                  levitated_in,
    input  wire logic                  at_rated_speed_in,
    input  wire logic                  speed_low_in,
    input  wire logic                  fault_detect_in,
    input  wire logic                  caution_shown_in,
    input  wire logic                  vent_active_in,
    input  wire logic [PRP_TEMP_W-1:0] temp_in,
    input  wire logic [PRP_TEMP_W-1:0] temp_setpoint_in,
    output logic                       remote_sel_relay_out,
    output logic                       levitation_relay_out,
    output logic                       spin_up_relay_out,
    output logic                       rated_make_out,
    output logic                       rated_break_out,
    output logic                       decel_relay_out,
    output logic                       fault_make_out,
    output logic                       fault_break_out,
    output logic                       thermal_make_out,
    output logic                       thermal_break_out,
    output logic                       caution_make_out,
    output logic                       caution_break_out,
    output logic                       vent_relay_out,
    output logic [1:0]                 pump_state_out
);

    localparam int FW = $clog2(FILT_CYC + 1) + 1;

    // ****************************************
    // synchronisers and stable-time filters
    // ****************************************
    logic [PRP_NC-1:0] raw_w;
    logic [PRP_NC-1:0] sync1_r;
    logic [PRP_NC-1:0] sync2_r;
    logic [PRP_NC-1:0] filt_w;
    logic [PRP_NC-1:0] filt_d_r;
    logic [PRP_NC-1:0] rise_w;

    assign raw_w = {panel_stop_in, panel_start_in, remote_select_in, rot_block_contact_in,
                    fault_clear_contact_in, stop_hold_contact_in, start_contact_in};

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= raw_w;
            sync2_r <= sync1_r;
        end
    end

    for (genvar g = 0; g < PRP_NC; g++) begin : g_filt
        logic [FW-1:0] cnt_r;
        logic          bit_r;
        always_ff @(posedge ref_clk_in) begin
            if (!rstn_in) begin
                cnt_r <= '0;
                bit_r <= 1'b0;
            end else if (sync2_r[g] == bit_r) begin
                cnt_r <= '0;
            end else if (cnt_r == FW'(FILT_CYC - 1)) begin
                cnt_r <= '0;
                bit_r <= sync2_r[g];
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
        assign filt_w[g] = bit_r;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            filt_d_r <= '0;
        end else begin
            filt_d_r <= filt_w;
        end
    end

    assign rise_w = filt_w & ~filt_d_r;

    // ****************************************
    // power-on window
    // ****************************************
    logic [FW:0] settle_r;
    logic        settled_w;
    logic        pwrup_r;
    logic        start_qual_w;

    assign settled_w = (settle_r == (FW + 1)'(2 * FILT_CYC));

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            settle_r <= '0;
        end else if (!settled_w) begin
            settle_r <= settle_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            pwrup_r <= 1'b1;
        end else if (start_qual_w || (settled_w && !filt_w[PRP_CI_START])) begin
            pwrup_r <= 1'b0;
        end
    end

    // ****************************************
    // start and fault-clear hold timers
    // ****************************************
    logic [PRP_HOLD_W-1:0] start_cnt_r;
    logic [PRP_HOLD_W-1:0] start_thr_w;
    logic [PRP_HOLD_W-1:0] clr_cnt_r;
    logic                  clr_qual_w;

    assign start_thr_w  = pwrup_r ? PRP_HOLD_W'(PWRUP_CYC - 1) : PRP_HOLD_W'(START_CYC - 1);
    assign start_qual_w = filt_w[PRP_CI_START] && (start_cnt_r == start_thr_w);
    assign clr_qual_w   = filt_w[PRP_CI_CLR] && (clr_cnt_r == PRP_HOLD_W'(CLR_CYC - 1));

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            start_cnt_r <= '0;
        end else if (!filt_w[PRP_CI_START]) begin
            start_cnt_r <= '0;
        end else if (start_cnt_r <= start_thr_w) begin
            start_cnt_r <= start_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            clr_cnt_r <= '0;
        end else if (!filt_w[PRP_CI_CLR]) begin
            clr_cnt_r <= '0;
        end else if (clr_cnt_r < PRP_HOLD_W'(CLR_CYC)) begin
            clr_cnt_r <= clr_cnt_r + 1'b1;
        end
    end

    // ****************************************
    // command decode
    // ****************************************
    logic remote_w;
    logic block_ok_w;
    logic start_cmd_w;
    logic stop_cmd_w;
    logic fault_r;
    logic fault_set_w;
    logic pending_r;
    logic go_w;

    assign remote_w    = filt_w[PRP_CI_SEL];
    assign block_ok_w  = !rot_block_enable_in || filt_w[PRP_CI_BLOCK];
    assign start_cmd_w = remote_w ?
        (single_contact_mode_in ? rise_w[PRP_CI_START]
                                : (filt_w[PRP_CI_HOLD] && start_qual_w))
        : rise_w[PRP_CI_PSTART];
    assign stop_cmd_w  = remote_w ?
        (single_contact_mode_in ? !filt_w[PRP_CI_START]
                                : !filt_w[PRP_CI_HOLD])
        : rise_w[PRP_CI_PSTOP];
    assign go_w = !stop_cmd_w && !fault_r &&
                  ((start_cmd_w && block_ok_w) || (pending_r && block_ok_w));
    assign fault_set_w = fault_detect_in && power_good_in && levitated_in;

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            pending_r <= 1'b0;
        end else if (remote_w && start_cmd_w && !block_ok_w && !fault_r && !stop_cmd_w) begin
            pending_r <= 1'b1;
        end else if (go_w || stop_cmd_w || !remote_w || fault_r) begin
            pending_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            fault_r <= 1'b0;
        end else if (fault_set_w) begin
            fault_r <= 1'b1;
        end else if (remote_w && clr_qual_w && !fault_detect_in) begin
            fault_r <= 1'b0;
        end
    end

    // ****************************************
    // pump state machine
    // ****************************************
    prp_state_type state_r;
    prp_state_type state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PRP_ST_IDLE: begin
                if (go_w) begin
                    state_nxt = PRP_ST_ACCEL;
                end
            end
            PRP_ST_ACCEL: begin
                if (stop_cmd_w || !block_ok_w || fault_r) begin
                    state_nxt = PRP_ST_BRAKE;
                end else if (at_rated_speed_in) begin
                    state_nxt = PRP_ST_RATED;
                end
            end
            PRP_ST_RATED: begin
                if (stop_cmd_w || !block_ok_w || fault_r) begin
                    state_nxt = PRP_ST_BRAKE;
                end
            end
            PRP_ST_BRAKE: begin
                if (go_w) begin
                    state_nxt = PRP_ST_ACCEL;
                end else if (speed_low_in) begin
                    state_nxt = PRP_ST_IDLE;
                end
            end
            default: begin
                state_nxt = PRP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            state_r <= PRP_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // status relays
    // ****************************************
    logic signed [PRP_TEMP_W:0] tdiff_w;
    logic                       in_range_w;

    assign tdiff_w    = $signed({temp_in[PRP_TEMP_W-1], temp_in})
                      - $signed({temp_setpoint_in[PRP_TEMP_W-1], temp_setpoint_in});
    assign in_range_w = (tdiff_w >= -(PRP_TEMP_W + 1)'(PRP_THERM_BAND))
                     && (tdiff_w <= (PRP_TEMP_W + 1)'(PRP_THERM_BAND));

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            remote_sel_relay_out <= 1'b0;
            levitation_relay_out <= 1'b0;
            vent_relay_out       <= 1'b0;
            caution_make_out     <= 1'b0;
            caution_break_out    <= 1'b1;
            thermal_make_out     <= 1'b0;
            thermal_break_out    <= 1'b1;
            fault_make_out       <= 1'b0;
            fault_break_out      <= 1'b1;
        end else begin
            remote_sel_relay_out <= remote_w;
            levitation_relay_out <= power_good_in && levitated_in;
            vent_relay_out       <= vent_active_in;
            caution_make_out     <= caution_shown_in;
            caution_break_out    <= !caution_shown_in;
            thermal_make_out     <= in_range_w;
            thermal_break_out    <= !in_range_w;
            fault_make_out       <= fault_r;
            fault_break_out      <= !fault_r;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rstn_in) begin
            spin_up_relay_out <= 1'b0;
            rated_make_out    <= 1'b0;
            rated_break_out   <= 1'b1;
            decel_relay_out   <= 1'b0;
            pump_state_out    <= PRP_ST_IDLE;
        end else begin
            spin_up_relay_out <= (state_r == PRP_ST_ACCEL);
            rated_make_out    <= (state_r == PRP_ST_RATED);
            rated_break_out   <= (state_r != PRP_ST_RATED);
            decel_relay_out   <= (state_r == PRP_ST_BRAKE);
            pump_state_out    <= state_r;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    a_spin_state: assert property ((state_r == PRP_ST_ACCEL) |=> spin_up_relay_out)
        else $error("spin-up relay not following acceleration");
    a_rated_pair: assert property ((rated_make_out != rated_break_out) and
        ((state_r == PRP_ST_RATED) |=> rated_make_out))
        else $error("rated changeover contacts wrong");
    a_decel_state: assert property ((state_r != PRP_ST_BRAKE) |=> !decel_relay_out)
        else $error("deceleration relay outside braking");
    a_run_onehot: assert property ($onehot0({spin_up_relay_out, rated_make_out,
        decel_relay_out}))
        else $error("more than one run indication");
    a_fault_set: assert property (fault_set_w |=> ##1 (fault_make_out && !fault_break_out))
        else $error("fault changeover not set");
    a_remote_sel: assert property (remote_w |=> remote_sel_relay_out)
        else $error("remote relay not closed");
    a_lev_fail: assert property (!power_good_in |=> !levitation_relay_out)
        else $error("levitation relay closed at power failure");
    a_vent_hold: assert property (vent_active_in [*2] |=> vent_relay_out)
        else $error("vent relay dropped while active");
    a_local_drop: assert property (!remote_w && start_cmd_w && !block_ok_w &&
        (state_r == PRP_ST_IDLE) |=> (state_r == PRP_ST_IDLE) && !pending_r)
        else $error("local start with block open not discarded");
    a_block_stop: assert property (((state_r == PRP_ST_ACCEL) ||
        (state_r == PRP_ST_RATED)) && !block_ok_w |=> (state_r == PRP_ST_BRAKE))
        else $error("block opening did not brake");
    a_brake_exit: assert property ((state_r == PRP_ST_BRAKE) && speed_low_in && !go_w
        |=> (state_r == PRP_ST_IDLE) ##1 !decel_relay_out)
        else $error("braking not left at low speed");
    a_pend_start: assert property (pending_r && block_ok_w && !stop_cmd_w && !fault_r &&
        (state_r == PRP_ST_IDLE) |=> (state_r == PRP_ST_ACCEL))
        else $error("pending start not launched");

    c_remote_run: cover property ((state_r == PRP_ST_ACCEL) && remote_w);
    c_pending: cover property (pending_r ##1 (state_r == PRP_ST_ACCEL));
    c_fault_clear: cover property (fault_r ##1 !fault_r);

endmodule

// *** tb/prp_host_model.sv ***
`timescale 1ns/1ps
// ****************************************
// host equipment contact model
// ****************************************
module prp_host_model #(
    parameter int FILT_CYC  = 4,
    parameter int START_CYC = 20,
    parameter int CLR_CYC   = 20
)(
    input  wire logic ref_clk_in,
    output logic      start_contact_out,
    output logic      stop_hold_contact_out,
    output logic      fault_clear_contact_out,
    output logic      rot_block_contact_out
);
    // sync plus filter plus margin
    localparam int LAT = FILT_CYC + 4;

    initial begin
        start_contact_out       = 1'b0;
        stop_hold_contact_out   = 1'b0;
        fault_clear_contact_out = 1'b0;
        rot_block_contact_out   = 1'b1;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic drive(input logic s, input logic h, input logic b);
        start_contact_out     = s;
        stop_hold_contact_out = h;
        rot_block_contact_out = b;
    endtask

    // hold closed first, then start for the minimum time plus extra
    task automatic start_two(input int extra);
        stop_hold_contact_out = 1'b1;
        step(1);
        start_contact_out = 1'b1;
        step(LAT + START_CYC + extra);
        start_contact_out = 1'b0;
        step(1);
    endtask

    // closure too short for the filter
    task automatic pulse_start(input int n);
        start_contact_out = 1'b1;
        step(n);
        start_contact_out = 1'b0;
        step(1);
    endtask

    task automatic clear_fault();
        fault_clear_contact_out = 1'b1;
        step(LAT + CLR_CYC);
        fault_clear_contact_out = 1'b0;
        step(1);
    endtask
endmodule

// *** tb/prp_remote_io_test.sv ***
`timescale 1ns/1ps
module prp_remote_io_test;
    import prp_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic ref_clk_in = 1'b0, rstn_in = 1'b0;
    logic start_c, hold_c, clear_c, block_c;
    logic remote_select_in = 1'b1, panel_start_in = 1'b0, panel_stop_in = 1'b0;
    logic single_contact_mode_in = 1'b0, rot_block_enable_in = 1'b1;
    logic power_good_in = 1'b1, levitated_in = 1'b1, at_rated_speed_in = 1'b0;
    logic speed_low_in = 1'b0, fault_detect_in = 1'b0;
    logic caution_shown_in = 1'b0, vent_active_in = 1'b0;
    logic [PRP_TEMP_W-1:0] temp_in = 9'h028, temp_setpoint_in = 9'h028;
    logic remote_sel_relay_out, levitation_relay_out, spin_up_relay_out;
    logic rated_make_out, rated_break_out, decel_relay_out, fault_make_out;
    logic fault_break_out, thermal_make_out, thermal_break_out;
    logic caution_make_out, caution_break_out, vent_relay_out;
    logic [1:0] pump_state_out;
    logic [PRP_TEMP_W-1:0] temps [4] = '{9'h01d, 9'h01e, 9'h032, 9'h033};
    int mismatches = 0, checks_done = 0, cycles = 0;

    always #20 ref_clk_in = ~ref_clk_in;

    prp_host_model i_host (
        .ref_clk_in(ref_clk_in), .start_contact_out(start_c),
        .stop_hold_contact_out(hold_c), .fault_clear_contact_out(clear_c),
        .rot_block_contact_out(block_c));

    prp_remote_io #(.FILT_CYC(4), .START_CYC(20), .PWRUP_CYC(60), .CLR_CYC(20)) i_dut (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .start_contact_in(start_c),
        .stop_hold_contact_in(hold_c), .fault_clear_contact_in(clear_c),
        .rot_block_contact_in(block_c), .remote_select_in(remote_select_in),
        .panel_start_in(panel_start_in), .panel_stop_in(panel_stop_in),
        .single_contact_mode_in(single_contact_mode_in),
        .rot_block_enable_in(rot_block_enable_in), .power_good_in(power_good_in),
        .levitated_in(levitated_in), .at_rated_speed_in(at_rated_speed_in),
        .speed_low_in(speed_low_in), .fault_detect_in(fault_detect_in),
        .caution_shown_in(caution_shown_in), .vent_active_in(vent_active_in),
        .temp_in(temp_in), .temp_setpoint_in(temp_setpoint_in),
        .remote_sel_relay_out(remote_sel_relay_out),
        .levitation_relay_out(levitation_relay_out), .spin_up_relay_out(spin_up_relay_out),
        .rated_make_out(rated_make_out), .rated_break_out(rated_break_out),
        .decel_relay_out(decel_relay_out), .fault_make_out(fault_make_out),
        .fault_break_out(fault_break_out), .thermal_make_out(thermal_make_out),
        .thermal_break_out(thermal_break_out), .caution_make_out(caution_make_out),
        .caution_break_out(caution_break_out), .vent_relay_out(vent_relay_out),
        .pump_state_out(pump_state_out));

    // ****************************************
    // helpers
    // ****************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    // bounded wait for a state, then one edge for the relays
    task automatic wait_state(input prp_state_type st, input int lim);
        int k;
        k = 0;
        while (pump_state_out !== st && k < lim) begin
            cyc(1);
            k++;
        end
        cyc(1);
        check("pump_state", pump_state_out, st);
    endtask

    task automatic run_relays(input prp_state_type st);
        check("spin_up", {1'b0, spin_up_relay_out}, {1'b0, st == PRP_ST_ACCEL});
        check("rated", {rated_make_out, rated_break_out},
              {st == PRP_ST_RATED, st != PRP_ST_RATED});
        check("decel", {1'b0, decel_relay_out}, {1'b0, st == PRP_ST_BRAKE});
    endtask

    task automatic finish_brake();
        speed_low_in = 1'b1;
        wait_state(PRP_ST_IDLE, 5);
        speed_low_in = 1'b0;
    endtask

    task automatic panel(input logic stop);
        panel_start_in = !stop;
        panel_stop_in  = stop;
        cyc(10);
        panel_start_in = 1'b0;
        panel_stop_in  = 1'b0;
        cyc(1);
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        cyc(3);
        i_host.drive(1'b1, 1'b1, 1'b1);
        check("reset_state", pump_state_out, PRP_ST_IDLE);
        check("reset_breaks", {rated_break_out, fault_break_out}, 2'h3);
        cyc(1);
        rstn_in = 1'b1;
        cyc(40);
        check("pwrup_wait", pump_state_out, PRP_ST_IDLE);
        cyc(32);
        i_host.drive(1'b0, 1'b1, 1'b1);
        wait_state(PRP_ST_ACCEL, 40);
        run_relays(PRP_ST_ACCEL);
        at_rated_speed_in = 1'b1;
        wait_state(PRP_ST_RATED, 5);
        run_relays(PRP_ST_RATED);
        at_rated_speed_in = 1'b0;
        i_host.drive(1'b0, 1'b0, 1'b1);
        wait_state(PRP_ST_BRAKE, 20);
        run_relays(PRP_ST_BRAKE);
        finish_brake();
        run_relays(PRP_ST_IDLE);
        i_host.drive(1'b0, 1'b1, 1'b1);
        cyc(10);
        i_host.start_two(0);
        wait_state(PRP_ST_ACCEL, 30);
        i_host.drive(1'b0, 1'b1, 1'b0);
        wait_state(PRP_ST_BRAKE, 20);
        finish_brake();
        i_host.drive(1'b0, 1'b1, 1'b1);
        cyc(40);
        check("reclose", pump_state_out, PRP_ST_IDLE);
        i_host.drive(1'b0, 1'b1, 1'b0);
        cyc(10);
        i_host.start_two(2);
        cyc(20);
        check("pending", pump_state_out, PRP_ST_IDLE);
        i_host.drive(1'b0, 1'b1, 1'b1);
        wait_state(PRP_ST_ACCEL, 20);
        fault_detect_in = 1'b1;
        cyc(3);
        check("fault", {fault_make_out, fault_break_out}, 2'h2);
        wait_state(PRP_ST_BRAKE, 5);
        fault_detect_in = 1'b0;
        finish_brake();
        remote_select_in = 1'b0;
        cyc(10);
        i_host.clear_fault();
        cyc(3);
        check("clear_local", {fault_make_out, fault_break_out}, 2'h2);
        remote_select_in = 1'b1;
        cyc(10);
        i_host.clear_fault();
        cyc(3);
        check("clear", {fault_make_out, fault_break_out}, 2'h1);
        remote_select_in = 1'b0;
        i_host.drive(1'b0, 1'b1, 1'b0);
        cyc(10);
        panel(1'b0);
        cyc(20);
        check("local_open", pump_state_out, PRP_ST_IDLE);
        i_host.drive(1'b0, 1'b1, 1'b1);
        cyc(40);
        check("local_late", pump_state_out, PRP_ST_IDLE);
        i_host.start_two(2);
        cyc(10);
        check("local_contact", pump_state_out, PRP_ST_IDLE);
        panel(1'b0);
        wait_state(PRP_ST_ACCEL, 10);
        panel(1'b1);
        wait_state(PRP_ST_BRAKE, 10);
        finish_brake();
        rot_block_enable_in = 1'b0;
        i_host.drive(1'b0, 1'b1, 1'b0);
        cyc(10);
        panel(1'b0);
        wait_state(PRP_ST_ACCEL, 10);
        panel(1'b1);
        wait_state(PRP_ST_BRAKE, 10);
        finish_brake();
        rot_block_enable_in = 1'b1;
        remote_select_in = 1'b1;
        single_contact_mode_in = 1'b1;
        i_host.drive(1'b0, 1'b0, 1'b1);
        cyc(10);
        i_host.pulse_start(3);
        cyc(20);
        check("glitch", pump_state_out, PRP_ST_IDLE);
        i_host.drive(1'b1, 1'b0, 1'b1);
        wait_state(PRP_ST_ACCEL, 40);
        i_host.drive(1'b0, 1'b0, 1'b1);
        wait_state(PRP_ST_BRAKE, 20);
        finish_brake();
        for (int m = 0; m < 2; m++) begin
            remote_select_in = m[0];
            power_good_in    = m[0];
            caution_shown_in = m[0];
            vent_active_in   = m[0];
            cyc(10);
            check("remote_sel", {1'b0, remote_sel_relay_out}, {1'b0, m[0]});
            check("levitation", {1'b0, levitation_relay_out}, {1'b0, m[0]});
            check("caution", {caution_make_out, caution_break_out}, {m[0], !m[0]});
            check("vent", {1'b0, vent_relay_out}, {1'b0, m[0]});
            for (int t = 0; t < 4; t++) begin
                temp_in = temps[t];
                cyc(2);
                check("thermal", {thermal_make_out, thermal_break_out},
                      {t == 1 || t == 2, t == 0 || t == 3});
            end
        end
        levitated_in = 1'b0;
        cyc(2);
        check("lev_drop", {1'b0, levitation_relay_out}, 2'h0);
        temp_setpoint_in = 9'h1f6;
        temp_in = 9'h000;
        cyc(2);
        check("thermal_neg", {thermal_make_out, thermal_break_out}, 2'h2);
        temp_in = 9'h1eb;
        cyc(2);
        check("thermal_low", {thermal_make_out, thermal_break_out}, 2'h1);
        wrap_up();
    end
endmodule
